// File: rtl/gpm_port.sv
// Function
// - pin value read returns real pin level, input or output.
// - unselected bits of pin value and detect status reads, and bits 31:8 of every read word, are zero.
// - eight-bit select mask, bit n means pin n.
// - at most one peripheral function per pin at a time.
// - a function claimed by a lower-letter port is ignored here.
// - drive strengths 2, 4, 8 mA and 8 mA with slew control.
// - extended variant also offers 6, 10 and 12 mA.
// - pad types push-pull, pull-up, pull-down, open-drain, analog.
// - optional wake pad type with high or low sense.
// - inputs keep full pad setting, pulls, analog and wake affect them.
// - pad read returns drive and type in write encoding.
// - protected pins need unlock key and commit before a pad or function change.
// - each pin detects falling, rising, both, low or high.
//
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`include "gpm_cfg.svh"
`default_nettype none

module gpm_port
    import gpm_pkg::*;
#(
    parameter int NFUNC = 15,
    parameter logic [7:0] PROT_PINS = 8'h0f,
    parameter bit EXT_DRIVE = 1'b1,
    parameter bit WAKE_SUPPORT = 1'b1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [7:0] pin_i,
    output logic [7:0] pin_o,
    output logic [7:0] pin_oe_n_o,
    output gpm_pad_s [7:0] pad_o,
    output logic [7:0] pull_up_o,
    output logic [7:0] pull_down_o,
    output logic [7:0] analog_o,
    output logic [7:0] wake_o,
    input wire logic [NFUNC-1:0] alt_out_i,
    input wire logic [NFUNC-1:0] alt_oe_i,
    output logic [NFUNC-1:0] alt_in_o,
    input wire logic [NFUNC-1:0] lower_claim_i,
    output logic [NFUNC-1:0] claim_o
);

    ////////////////////////////////////////////////////////////////////////
    // state
    logic [7:0] mask_r;
    logic [7:0] data_r;
    logic [7:0] dir_r;
    gpm_pad_s [7:0] pad_r;
    gpm_func_t [7:0] func_r;
    gpm_det_e [7:0] det_r;
    logic locked_r;
    logic [7:0] commit_r;
    logic [7:0] dstat_r;
    logic [7:0] prev_r;
    logic ack_r;
    logic [31:0] rdat_r;

    ////////////////////////////////////////////////////////////////////////
    // bus decode: one request per ack, write takes effect as ack rises
    // the master sees ack from the same edge on which the write lands
    wire req = wb_cyc_i & wb_stb_i & ~ack_r;
    wire wr = req & wb_we_i & wb_sel_i[0];
    wire [7:0] wbyte = wb_dat_i[7:0];
    wire wr_mask = wr & (wb_adr_i == `GPM_ADR_MASK);
    wire wr_data = wr & (wb_adr_i == `GPM_ADR_DATA);
    wire wr_dir = wr & (wb_adr_i == `GPM_ADR_DIR);
    wire wr_pad = wr & (wb_adr_i == `GPM_ADR_PAD);
    wire wr_func = wr & (wb_adr_i == `GPM_ADR_FUNC);
    wire wr_det = wr & (wb_adr_i == `GPM_ADR_DTYPE);
    wire wr_lock = req & wb_we_i & (wb_adr_i == `GPM_ADR_LOCK);
    wire wr_commit = wr & (wb_adr_i == `GPM_ADR_COMMIT);
    wire wr_dstat = wr & (wb_adr_i == `GPM_ADR_DSTAT);

    // pins open for reconfiguration: unprotected, or committed
    // commit bits survive a relock, so software must clear them itself
    wire [7:0] cfg_open = ~PROT_PINS | commit_r;
    wire [7:0] cfg_sel = mask_r & cfg_open;

    // pad write fields and their legality
    wire [2:0] wr_drv = wbyte[`GPM_PAD_DRV_MSB:`GPM_PAD_DRV_LSB];
    wire [2:0] wr_typ = wbyte[`GPM_PAD_TYP_MSB:`GPM_PAD_TYP_LSB];
    wire drv_ok = (wr_drv <= `GPM_DRV_MAX_BASE)
        | (EXT_DRIVE & (wr_drv <= `GPM_DRV_MAX_EXT));
    wire typ_ok = (wr_typ <= `GPM_TYP_MAX_BASE)
        | (WAKE_SUPPORT & (wr_typ <= `GPM_TYP_MAX_WAKE));
    wire pad_go = wr_pad & drv_ok & typ_ok;
    wire func_go = wr_func & (wbyte[3:0] <= 4'(NFUNC));
    wire det_go = wr_det & (wbyte[2:0] <= 3'(GPM_DET_HIGH));

    ////////////////////////////////////////////////////////////////////////
    // lowest selected pin, the one a pad or function read reports
    logic [2:0] rd_pin;
    always_comb begin
        rd_pin = 3'h0;
        for (int p = 7; p >= 0; p--) begin
            if (mask_r[p]) begin
                rd_pin = 3'(p);
            end
        end
    end

    // read data selection, upper bits always zero
    wire [7:0] pin_view = pin_i & mask_r;
    wire [7:0] pad_view = {1'b0, pad_r[rd_pin].ptype, 1'b0,
        pad_r[rd_pin].drive};
    wire [7:0] rd_byte =
        (wb_adr_i == `GPM_ADR_MASK) ? mask_r :
        (wb_adr_i == `GPM_ADR_DATA) ? pin_view :
        (wb_adr_i == `GPM_ADR_DIR) ? dir_r :
        (wb_adr_i == `GPM_ADR_PAD) ? pad_view :
        (wb_adr_i == `GPM_ADR_FUNC) ? {4'h0, func_r[rd_pin]} :
        (wb_adr_i == `GPM_ADR_DTYPE) ? {5'h00, det_r[rd_pin]} :
        (wb_adr_i == `GPM_ADR_LOCK) ? {7'h00, locked_r} :
        (wb_adr_i == `GPM_ADR_COMMIT) ? commit_r :
        (wb_adr_i == `GPM_ADR_DSTAT) ? (dstat_r & mask_r) :
        8'h00;

    ////////////////////////////////////////////////////////////////////////
    // alternate function routing: first pin of a function wins
    logic [7:0] alt_on;
    logic [7:0][3:0] alt_idx;
    logic [NFUNC-1:0] here_claim;
    always_comb begin
        alt_on = 8'h00;
        alt_idx = '0;
        here_claim = '0;
        for (int p = 0; p < 8; p++) begin
            // code zero wraps the index, but it is never used then
            alt_idx[p] = 4'(func_r[p] - 4'h1);
            if (func_r[p] != `GPM_RST_FUNC
                && !lower_claim_i[alt_idx[p]]
                && !here_claim[alt_idx[p]]) begin
                alt_on[p] = 1'b1;
                here_claim[alt_idx[p]] = 1'b1;
            end
        end
    end

    // peripheral inputs see the level of the pin that carries them
    logic [NFUNC-1:0] alt_in_nxt;
    always_comb begin
        alt_in_nxt = '0;
        for (int p = 0; p < 8; p++) begin
            if (alt_on[p]) begin
                alt_in_nxt[alt_idx[p]] = pin_i[p];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad drive, pulls, analog and wake per pin
    logic [7:0] pin_nxt;
    logic [7:0] oe_n_nxt;
    logic [7:0] pu_nxt;
    logic [7:0] pd_nxt;
    logic [7:0] an_nxt;
    logic [7:0] wake_nxt;
    logic [7:0] hit;
    always_comb begin
        pin_nxt = 8'h00;
        oe_n_nxt = 8'hff;
        pu_nxt = 8'h00;
        pd_nxt = 8'h00;
        an_nxt = 8'h00;
        wake_nxt = 8'h00;
        hit = 8'h00;
        for (int p = 0; p < 8; p++) begin
            pin_nxt[p] = alt_on[p] ? alt_out_i[alt_idx[p]] : data_r[p];
            oe_n_nxt[p] = ~(alt_on[p] ? alt_oe_i[alt_idx[p]] : dir_r[p]);
            // pulls, analog and wake act on inputs too, open-drain only on drive
            pu_nxt[p] = pad_r[p].ptype == GPM_TYP_PULLUP;
            pd_nxt[p] = pad_r[p].ptype == GPM_TYP_PULLDOWN;
            case (pad_r[p].ptype)
                GPM_TYP_OPEN_DRAIN: begin
                    oe_n_nxt[p] = oe_n_nxt[p] | pin_nxt[p];
                    pin_nxt[p] = 1'b0;
                end
                GPM_TYP_ANALOG: begin
                    oe_n_nxt[p] = 1'b1;
                    an_nxt[p] = 1'b1;
                end
                GPM_TYP_WAKE_HIGH: begin
                    wake_nxt[p] = pin_i[p];
                end
                GPM_TYP_WAKE_LOW: begin
                    wake_nxt[p] = ~pin_i[p];
                end
                default: begin
                end
            endcase
            case (det_r[p])
                GPM_DET_FALL: hit[p] = prev_r[p] & ~pin_i[p];
                GPM_DET_RISE: hit[p] = ~prev_r[p] & pin_i[p];
                GPM_DET_BOTH: hit[p] = prev_r[p] ^ pin_i[p];
                GPM_DET_LOW: hit[p] = ~pin_i[p];
                GPM_DET_HIGH: hit[p] = pin_i[p];
                default: hit[p] = 1'b0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus answer and port-wide registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
            rdat_r <= 32'h0000_0000;
            mask_r <= `GPM_RST_BYTE;
            data_r <= `GPM_RST_BYTE;
            dir_r <= `GPM_RST_BYTE;
            locked_r <= 1'b1;
            commit_r <= `GPM_RST_BYTE;
            dstat_r <= `GPM_RST_BYTE;
            prev_r <= `GPM_RST_BYTE;
        end else if (ce_i) begin
            ack_r <= req;
            rdat_r <= {24'h00_0000, rd_byte};
            prev_r <= pin_i;
            if (wr_mask) begin
                mask_r <= wbyte;
            end
            if (wr_data) begin
                data_r <= (data_r & ~mask_r) | (wbyte & mask_r);
            end
            if (wr_dir) begin
                dir_r <= (dir_r & ~mask_r) | (wbyte & mask_r);
            end
            if (wr_lock) begin
                locked_r <= wb_dat_i != `GPM_UNLOCK_KEY;
            end
            if (wr_commit && !locked_r) begin
                commit_r <= wbyte & PROT_PINS;
            end
            // a new detection wins over a clear in the same cycle
            dstat_r <= (dstat_r & ~(wr_dstat ? wbyte & mask_r : 8'h00))
                | hit;
        end
    end

    // per-pin pad, function and detection settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_r <= '0;
            func_r <= '0;
            det_r <= {8{GPM_DET_FALL}};
        end else if (ce_i) begin
            for (int p = 0; p < 8; p++) begin
                if (pad_go && cfg_sel[p]) begin
                    pad_r[p] <= {gpm_ptype_e'(wr_typ),
                        gpm_drive_e'(wr_drv)};
                end
                if (func_go && cfg_sel[p]) begin
                    func_r[p] <= wbyte[3:0];
                end
                if (det_go && mask_r[p]) begin
                    det_r[p] <= gpm_det_e'(wbyte[2:0]);
                end
            end
        end
    end

    // every output leaves from a flip-flop
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o <= 8'h00;
            pin_oe_n_o <= 8'hff;
            pad_o <= '0;
            pull_up_o <= 8'h00;
            pull_down_o <= 8'h00;
            analog_o <= 8'h00;
            wake_o <= 8'h00;
            alt_in_o <= '0;
            claim_o <= '0;
        end else if (ce_i) begin
            pin_o <= pin_nxt;
            pin_oe_n_o <= oe_n_nxt;
            pad_o <= pad_r;
            pull_up_o <= pu_nxt;
            pull_down_o <= pd_nxt;
            analog_o <= an_nxt;
            wake_o <= wake_nxt;
            alt_in_o <= alt_in_nxt;
            claim_o <= lower_claim_i | here_claim;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = rdat_r;

endmodule : gpm_port
`default_nettype wire

// File: include/gpm_cfg.svh
`ifndef GPM_CFG_SVH
`define GPM_CFG_SVH

// register byte offsets on the wishbone slave
`define GPM_ADR_MASK 8'h00
`define GPM_ADR_DATA 8'h04
`define GPM_ADR_DIR 8'h08
`define GPM_ADR_PAD 8'h0c
`define GPM_ADR_FUNC 8'h10
`define GPM_ADR_DTYPE 8'h14
`define GPM_ADR_LOCK 8'h18
`define GPM_ADR_COMMIT 8'h1c
`define GPM_ADR_DSTAT 8'h20

// pad word field positions
`define GPM_PAD_DRV_LSB 0
`define GPM_PAD_DRV_MSB 2
`define GPM_PAD_TYP_LSB 4
`define GPM_PAD_TYP_MSB 6

// highest legal codes for drive strength and pad type
`define GPM_DRV_MAX_BASE 3'h3
`define GPM_DRV_MAX_EXT 3'h6
`define GPM_TYP_MAX_BASE 3'h4
`define GPM_TYP_MAX_WAKE 3'h6

// unlock key value is arbitrary
`define GPM_UNLOCK_KEY 32'h5a5a_c3c3

// reset values
`define GPM_RST_BYTE 8'h00
`define GPM_RST_FUNC 4'h0

`endif

// File: include/gpm_pkg.sv
`default_nettype none
package gpm_pkg;
    // pad drive strength codes
    typedef enum logic [2:0] {
        GPM_DRV_2MA = 3'b000,
        GPM_DRV_4MA = 3'b001,
        GPM_DRV_8MA = 3'b010,
        GPM_DRV_8MA_SLEW = 3'b011,
        GPM_DRV_6MA = 3'b100,
        GPM_DRV_10MA = 3'b101,
        GPM_DRV_12MA = 3'b110
    } gpm_drive_e;

    // pad type codes
    typedef enum logic [2:0] {
        GPM_TYP_PUSH_PULL = 3'b000,
        GPM_TYP_PULLUP = 3'b001,
        GPM_TYP_PULLDOWN = 3'b010,
        GPM_TYP_OPEN_DRAIN = 3'b011,
        GPM_TYP_ANALOG = 3'b100,
        GPM_TYP_WAKE_HIGH = 3'b101,
        GPM_TYP_WAKE_LOW = 3'b110
    } gpm_ptype_e;

    // edge or level detection codes
    typedef enum logic [2:0] {
        GPM_DET_FALL = 3'b000,
        GPM_DET_RISE = 3'b001,
        GPM_DET_BOTH = 3'b010,
        GPM_DET_LOW = 3'b011,
        GPM_DET_HIGH = 3'b100
    } gpm_det_e;

    // one pad setting
    typedef struct packed {
        gpm_ptype_e ptype;
        gpm_drive_e drive;
    } gpm_pad_s;

    // alternate function code, zero is plain port logic
    typedef logic [3:0] gpm_func_t;
endpackage : gpm_pkg
`default_nettype wire

// File: verif/gpm_port_asserts.sv
`default_nettype none
module gpm_port_asserts
    import gpm_pkg::*;
#(
    parameter int NFUNC = 15
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic [7:0] pin_oe_n_o,
    input wire gpm_pad_s [7:0] pad_o,
    input wire logic [7:0] pull_up_o,
    input wire logic [7:0] analog_o,
    input wire logic [NFUNC-1:0] alt_in_o,
    input wire logic [NFUNC-1:0] lower_claim_i,
    input wire logic [NFUNC-1:0] claim_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] an_m;
    logic [7:0] pu_m;
    logic [7:0] bad_m;

    // per-pin views of the pad setting
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            an_m[i] = pad_o[i].ptype == GPM_TYP_ANALOG;
            pu_m[i] = pad_o[i].ptype == GPM_TYP_PULLUP;
            bad_m[i] = (&pad_o[i].drive) || (&pad_o[i].ptype);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i || !ce_i);
    ////////////////////////////////////////
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
        |=> wb_ack_o) else $error("request not acknowledged");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_read_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    a_code_legal: assert property (bad_m == 8'h00)
        else $error("pad code out of range");
    a_analog_float: assert property ($stable(an_m)[*4]
        |-> (an_m & ~pin_oe_n_o) == 8'h00) else $error("analog pad driven");
    a_analog_flag: assert property ($stable(an_m)[*4]
        |-> analog_o == an_m) else $error("analog flag mismatch");
    a_pullup_flag: assert property ($stable(pu_m)[*4]
        |-> pull_up_o == pu_m) else $error("pull-up flag mismatch");
    a_claim_chain: assert property ($stable(lower_claim_i)[*4]
        |-> (claim_o & lower_claim_i) == lower_claim_i)
        else $error("lower claim not passed on");
    a_lower_wins: assert property ($stable(lower_claim_i)[*4]
        |-> (alt_in_o & lower_claim_i) == '0)
        else $error("claimed function still routed");
endmodule : gpm_port_asserts

bind gpm_port gpm_port_asserts #(.NFUNC(NFUNC)) u_chk (.clk_i, .rst_i,
    .ce_i, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .pin_oe_n_o,
    .pad_o, .pull_up_o, .analog_o, .alt_in_o, .lower_claim_i, .claim_o);
`default_nettype wire

// File: verif/gpm_board.sv
`default_nettype none
module gpm_board (
    input wire logic clk_i,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe_n_o,
    input wire logic [7:0] pull_up_o,
    input wire logic [7:0] pull_down_o,
    input wire logic [7:0] ext_en_i,
    input wire logic [7:0] ext_val_i,
    output logic [7:0] pin_lvl_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] flt_r = 8'h55;

    // an undriven pin shows a pattern that flips every cycle
    always @(posedge clk_i) begin
        flt_r <= ~flt_r;
    end

    // pad drive wins, then the board driver, then the weak pulls
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n_o[i]) begin
                pin_lvl_o[i] = pin_o[i];
            end else if (ext_en_i[i]) begin
                pin_lvl_o[i] = ext_val_i[i];
            end else if (pull_up_o[i] || pull_down_o[i]) begin
                pin_lvl_o[i] = pull_up_o[i];
            end else begin
                pin_lvl_o[i] = flt_r[i];
            end
        end
    end
endmodule : gpm_board
`default_nettype wire

// File: verif/gpm_port_tb.sv
`include "gpm_cfg.svh"
`default_nettype none
module gpm_port_tb
    import gpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic ce = 1'b1;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o;
    logic [7:0] pin_o, pin_oe_n_o, pull_up_o, pull_down_o, lvl;
    logic [7:0] ext_en = 8'h00;
    logic [7:0] ext_val = 8'h00;
    logic [14:0] alt_out_i = 15'h0;
    logic [14:0] alt_oe_i = 15'h0;
    logic [14:0] lower_claim_i = 15'h0;
    logic [14:0] alt_in_o, claim_o;
    gpm_pad_s [7:0] pad_o;
    logic [7:0] wake;
    int error_cnt = 0;
    int n_compared = 0;

    gpm_port dut (.clk_i, .rst_i, .ce_i(ce), .wb_cyc_i, .wb_stb_i,
        .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o,
        .wb_ack_o, .pin_i(lvl), .pin_o, .pin_oe_n_o, .pad_o, .pull_up_o,
        .pull_down_o, .analog_o(), .wake_o(wake), .alt_out_i, .alt_oe_i,
        .alt_in_o, .lower_claim_i, .claim_o);
    gpm_board u_board (.clk_i, .pin_o, .pin_oe_n_o, .pull_up_o,
        .pull_down_o, .ext_en_i(ext_en), .ext_val_i(ext_val),
        .pin_lvl_o(lvl));
    ////////////////////////////////////////
    // one classic bus cycle, entered just after a rising edge
    task automatic wb(input logic w, input logic [7:0] a,
            input logic [31:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // wait for ack however long it takes; the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdc

    task automatic t_pins;
        ext_en <= 8'hf0;
        ext_val <= 8'ha0;
        wb(1'b1, `GPM_ADR_MASK, 32'hff);
        wb(1'b1, `GPM_ADR_DIR, 32'h0f);
        wb(1'b1, `GPM_ADR_DATA, 32'h05);
        rdc(`GPM_ADR_DATA, 32'ha5);
        wb(1'b1, `GPM_ADR_MASK, 32'h3c);
        rdc(`GPM_ADR_DATA, 32'h24);
        rdc(8'h40, 32'h0);
    endtask : t_pins

    task automatic t_pad;
        logic [2:0] c;
        ext_en <= 8'he0;
        wb(1'b1, `GPM_ADR_MASK, 32'h10);
        for (int i = 0; i < 7; i++) begin
            c = 3'(i);
            wb(1'b1, `GPM_ADR_PAD, {25'h0, c, 1'b0, c});
            rdc(`GPM_ADR_PAD, {25'h0, c, 1'b0, c});
            chk({26'h0, pad_o[4]}, {26'h0, c, c});
        end
        wb(1'b1, `GPM_ADR_PAD, 32'h77);
        rdc(`GPM_ADR_PAD, 32'h66);
        wb(1'b1, `GPM_ADR_PAD, 32'h10);
        repeat (3) @(posedge clk_i);
        rdc(`GPM_ADR_DATA, 32'h10);
        wb(1'b1, `GPM_ADR_PAD, 32'h20);
        repeat (3) @(posedge clk_i);
        rdc(`GPM_ADR_DATA, 32'h0);
        wb(1'b1, `GPM_ADR_MASK, 32'h20);
        rdc(`GPM_ADR_PAD, 32'h0);
    endtask : t_pad

    task automatic t_lock;
        rdc(`GPM_ADR_LOCK, 32'h1);
        wb(1'b1, `GPM_ADR_MASK, 32'h03);
        wb(1'b1, `GPM_ADR_PAD, 32'h12);
        rdc(`GPM_ADR_PAD, 32'h0);
        wb(1'b1, `GPM_ADR_LOCK, `GPM_UNLOCK_KEY);
        rdc(`GPM_ADR_LOCK, 32'h0);
        wb(1'b1, `GPM_ADR_COMMIT, 32'h01);
        wb(1'b1, `GPM_ADR_PAD, 32'h12);
        rdc(`GPM_ADR_PAD, 32'h12);
        wb(1'b1, `GPM_ADR_MASK, 32'h02);
        rdc(`GPM_ADR_PAD, 32'h0);
        wb(1'b1, `GPM_ADR_LOCK, 32'h0);
        rdc(`GPM_ADR_LOCK, 32'h1);
    endtask : t_lock

    // pin 7 is an input held high by the board
    task automatic t_func;
        lower_claim_i <= 15'h1;
        wb(1'b1, `GPM_ADR_MASK, 32'h80);
        wb(1'b1, `GPM_ADR_FUNC, 32'h1);
        repeat (3) @(posedge clk_i);
        chk({17'h0, alt_in_o}, 32'h0);
        lower_claim_i <= 15'h0;
        repeat (3) @(posedge clk_i);
        chk({17'h0, alt_in_o}, 32'h1);
        wb(1'b1, `GPM_ADR_FUNC, 32'h2);
        repeat (3) @(posedge clk_i);
        chk({17'h0, alt_in_o}, 32'h2);
    endtask : t_func

    // pin 6 is a board-driven input for wake, freeze and detect checks
    task automatic t_det;
        wb(1'b1, `GPM_ADR_MASK, 32'h40);
        wb(1'b1, `GPM_ADR_PAD, 32'h50);
        repeat (2) @(posedge clk_i);
        chk({31'h0, wake[6]}, 32'h0);
        wb(1'b1, `GPM_ADR_PAD, 32'h60);
        repeat (2) @(posedge clk_i);
        chk({31'h0, wake[6]}, 32'h1);
        ce <= 1'b0;
        ext_val <= 8'he0;
        repeat (3) @(posedge clk_i);
        chk({31'h0, wake[6]}, 32'h1);
        ce <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({31'h0, wake[6]}, 32'h0);
        wb(1'b1, `GPM_ADR_DTYPE, 32'h1);
        wb(1'b1, `GPM_ADR_DSTAT, 32'h40);
        rdc(`GPM_ADR_DSTAT, 32'h0);
        ext_val <= 8'ha0;
        repeat (2) @(posedge clk_i);
        rdc(`GPM_ADR_DSTAT, 32'h0);
        ext_val <= 8'he0;
        repeat (2) @(posedge clk_i);
        rdc(`GPM_ADR_DSTAT, 32'h40);
        wb(1'b1, `GPM_ADR_DTYPE, 32'h4);
        rdc(`GPM_ADR_DTYPE, 32'h4);
        wb(1'b1, `GPM_ADR_DSTAT, 32'h40);
        rdc(`GPM_ADR_DSTAT, 32'h40);
    endtask : t_det

    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    // clock, main sequence and watchdog
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_lock;
        t_pins;
        t_pad;
        t_func;
        t_det;
        test_done;
    end
    initial begin
        #100000;
        error_cnt++;
        test_done;
    end
endmodule : gpm_port_tb
`default_nettype wire
